//--- logic/eci_pkg.sv
package eci_pkg;
    // ==========================================================
    // register map (byte addresses, one word each)
    // ==========================================================
    localparam logic [11:0] ECI_CTRL_OFS   = 12'h000;  // enable
    localparam logic [11:0] ECI_OUT_OFS    = 12'h004;  // output state
    localparam logic [11:0] ECI_PINS_OFS   = 12'h008;  // live status pins
    localparam logic [11:0] ECI_ISTAT_OFS  = 12'h00c;  // sticky events
    localparam logic [11:0] ECI_IMASK_OFS  = 12'h010;  // event mask
    // ==========================================================
    // field layout
    // ==========================================================
    localparam int ECI_EN_BIT   = 0;   // ctrl: port enable
    localparam int ECI_OUT_BIT  = 0;   // out: power output on
    localparam int ECI_NCMD     = 7;   // command inputs
    localparam int ECI_NSTAT    = 7;   // status pins 1..7
    localparam int ECI_NRSV     = 7;   // undefined and reserved outputs
    // command indices
    localparam int ECI_C_OFF    = 0;
    localparam int ECI_C_ON     = 1;
    localparam int ECI_C_START  = 2;
    localparam int ECI_C_STOP   = 3;
    localparam int ECI_C_HOLD   = 4;
    localparam int ECI_C_BR1    = 5;
    localparam int ECI_C_BR2    = 6;
    // ==========================================================
    // reset values
    // ==========================================================
    localparam logic       ECI_EN_RST   = 1'b0;
    localparam logic       ECI_OUT_RST  = 1'b0;
    localparam logic [6:0] ECI_CMD_IDLE = 7'h7f;  // pulled-up lines idle high
    localparam logic [6:0] ECI_MASK_RST = 7'h00;
endpackage : eci_pkg

//--- logic/eci_ext_ctrl_io.sv
`timescale 1ns/10ps
module eci_ext_ctrl_io
    import eci_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // command pins, active low, falling edge acts
    input  wire logic        cmd_out_off_n,
    input  wire logic        cmd_out_on_n,
    input  wire logic        cmd_seq_start_n,
    input  wire logic        cmd_seq_stop_n,
    input  wire logic        cmd_seq_hold_n,
    input  wire logic        cmd_seq_br1_n,
    input  wire logic        cmd_seq_br2_n,
    input  wire logic        undef_in,
    // device internal state
    input  wire logic        src_power_on,
    input  wire logic        sw_busy,
    input  wire logic        pos_peak_current_limit_flag,
    input  wire logic        neg_peak_current_limit_flag,
    input  wire logic        rms_current_limit_flag,
    input  wire logic        power_limit_flag,
    input  wire logic [1:0]  seq_sync_in,
    input  wire logic        seq_trig_in,
    // command pulses toward the sequencer
    output logic             seq_start_pulse,
    output logic             seq_stop_pulse,
    output logic             seq_hold_pulse,
    output logic             seq_br1_pulse,
    output logic             seq_br2_pulse,
    // power output control
    output logic             output_on,
    // status pins
    output logic             st_power,
    output logic             st_output,
    output logic             st_limit,
    output logic             st_busy,
    output logic [1:0]       st_seq_sync,
    output logic             st_trigger,
    output logic [6:0]       st_spare,
    output logic             irq
);
    // ==========================================================
    // storage
    // ==========================================================
    logic             en_r;       // port enable
    logic             out_r;      // power output state
    logic [6:0]       cmd_prev_r; // last sampled command levels
    logic [6:0]       cmd_in;     // current command levels
    logic [6:0]       fall;       // falling edge seen this cycle
    logic [6:0]       pulse_r;    // registered command pulses
    logic [6:0]       stat_r;     // status pin flops
    logic [6:0]       istat_r;    // sticky events
    logic [6:0]       imask_r;    // event mask
    logic [31:0]      prdata_r;   // read data flop
    logic             wr_en;      // apb write access
    logic             rd_en;      // apb read access
    logic             map_hit;    // address decodes
    logic [6:0]       rd_clr;     // events cleared by status read
    logic             lim_any;    // any limiter active

    assign cmd_in = {cmd_seq_br2_n, cmd_seq_br1_n, cmd_seq_hold_n,
                     cmd_seq_stop_n, cmd_seq_start_n, cmd_out_on_n,
                     cmd_out_off_n};

    // ==========================================================
    // apb decode
    // ==========================================================
    // zero wait states: every access completes in its access cycle
    assign pready  = 1'b1;
    assign map_hit = (paddr == ECI_CTRL_OFS) || (paddr == ECI_OUT_OFS) ||
                     (paddr == ECI_PINS_OFS) || (paddr == ECI_ISTAT_OFS) ||
                     (paddr == ECI_IMASK_OFS);
    // unmapped offsets answer with an error rather than fail silently
    assign pslverr = psel && penable && !map_hit;
    assign wr_en   = psel && penable && pwrite && map_hit;
    assign rd_en   = psel && penable && !pwrite && map_hit;
    // the clearing read empties every bit that it has just returned
    assign rd_clr  = (rd_en && paddr == ECI_ISTAT_OFS) ? 7'h7f : 7'h00;
    assign prdata  = prdata_r;
    // a write to a hole is refused and must leave every register alone
    chk_drop_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr && pwrite |=> $stable(en_r) && $stable(imask_r))
        else $error("unmapped write landed");

    // ==========================================================
    // edge detection, one flop per command line
    // ==========================================================
    // inputs are synchronous to pclk, so no synchroniser is needed;
    // history resets to the idle high level, so a line resting at its
    // pull-up level shows no false edge once reset is released
    genvar gi;
    generate
        for (gi = 0; gi < ECI_NCMD; gi++) begin : g_edge
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cmd_prev_r[gi] <= ECI_CMD_IDLE[gi];
                end else begin
                    cmd_prev_r[gi] <= cmd_in[gi];
                end
            end
            assign fall[gi] = cmd_prev_r[gi] && !cmd_in[gi];
            // every line, not only start, must turn its edge into one pulse
            chk_line_edge: assert property (@(posedge pclk) disable iff (!presetn)
                en_r && $past(cmd_in[gi]) && !cmd_in[gi] |=> pulse_r[gi])
                else $error("command edge missed");
            // the line must rise again before it can act again
            chk_pulse_once: assert property (@(posedge pclk) disable iff (!presetn)
                pulse_r[gi] |=> !pulse_r[gi]) else $error("command pulse too long");
        end
    endgenerate

    // ==========================================================
    // control register
    // ==========================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_r <= ECI_EN_RST;
        end else if (wr_en && paddr == ECI_CTRL_OFS) begin
            en_r <= pwdata[ECI_EN_BIT];
        end
    end
    // software sets and clears the enable at the access edge of the write
    chk_en_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == ECI_CTRL_OFS |=> en_r == $past(pwdata[ECI_EN_BIT]))
        else $error("enable write lost");

    // ==========================================================
    // command pulses, only while enabled
    // ==========================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_r <= 7'h00;
        end else begin
            pulse_r <= en_r ? fall : 7'h00;
        end
    end
    // registered so the sequencer sees one clean strobe per edge
    assign seq_start_pulse = pulse_r[ECI_C_START];
    assign seq_stop_pulse  = pulse_r[ECI_C_STOP];
    assign seq_hold_pulse  = pulse_r[ECI_C_HOLD];
    assign seq_br1_pulse   = pulse_r[ECI_C_BR1];
    assign seq_br2_pulse   = pulse_r[ECI_C_BR2];

    // ==========================================================
    // power output state
    // ==========================================================
    // a pin command beats a software write in the same cycle, and off
    // beats on: when in doubt the safe state is output off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_r <= ECI_OUT_RST;
        end else if (en_r && fall[ECI_C_OFF]) begin
            out_r <= 1'b0;
        end else if (en_r && fall[ECI_C_ON]) begin
            out_r <= 1'b1;
        end else if (wr_en && paddr == ECI_OUT_OFS) begin
            out_r <= pwdata[ECI_OUT_BIT];
        end
    end
    assign output_on = out_r;
    // on acts only when off is not struck in the same cycle
    chk_on_edge: assert property (@(posedge pclk) disable iff (!presetn)
        en_r && fall[ECI_C_ON] && !fall[ECI_C_OFF] |=> output_on)
        else $error("on edge missed");
    // a software write lands unless a pin command overrides it
    chk_out_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == ECI_OUT_OFS && !(en_r && (fall[ECI_C_OFF] || fall[ECI_C_ON]))
        |=> output_on == $past(pwdata[ECI_OUT_BIT])) else $error("output write lost");

    // ==========================================================
    // status pins
    // ==========================================================
    // the limiter line is one or of all four limiter flags
    assign lim_any = pos_peak_current_limit_flag || neg_peak_current_limit_flag ||
                     rms_current_limit_flag || power_limit_flag;
    // pins are always driven; while disabled they sit at 0
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_r <= 7'h00;
        end else if (en_r) begin
            stat_r[0]   <= src_power_on;
            stat_r[1]   <= out_r;
            stat_r[2]   <= lim_any;
            stat_r[3]   <= sw_busy;
            stat_r[5:4] <= seq_sync_in;
            stat_r[6]   <= seq_trig_in;
        end else begin
            stat_r <= 7'h00;
        end
    end
    assign st_power    = stat_r[0];
    assign st_output   = stat_r[1];
    assign st_limit    = stat_r[2];
    assign st_busy     = stat_r[3];
    assign st_seq_sync = stat_r[5:4];
    assign st_trigger  = stat_r[6];
    // undefined input goes nowhere; spares are tied inactive
    assign st_spare    = 7'h00;

    // ==========================================================
    // interrupt status and mask
    // ==========================================================
    // a new edge in the cycle of the clearing read stays set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            istat_r <= 7'h00;
        end else begin
            istat_r <= (istat_r & ~rd_clr) | pulse_r;
        end
    end
    // an event must never be lost, even to a clearing read in its cycle
    chk_istat_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        pulse_r != 7'h00 |=> (istat_r & $past(pulse_r)) == $past(pulse_r))
        else $error("event not latched");
    // a read of the status word with no new event leaves it empty
    chk_read_clear: assert property (@(posedge pclk) disable iff (!presetn)
        rd_en && paddr == ECI_ISTAT_OFS && pulse_r == 7'h00 |=> istat_r == 7'h00)
        else $error("status not cleared");

    // a set mask bit lets its event raise the interrupt
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            imask_r <= ECI_MASK_RST;
        end else if (wr_en && paddr == ECI_IMASK_OFS) begin
            imask_r <= pwdata[6:0];
        end
    end

    // level output: stays high until the status read clears the bit
    assign irq = |(istat_r & imask_r);
    // interrupt stays quiet while every event is masked off
    chk_irq_masked: assert property (@(posedge pclk) disable iff (!presetn)
        imask_r == 7'h00 |-> !irq) else $error("masked interrupt raised");

    // ==========================================================
    // read data
    // ==========================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            // setup cycle: capture so data is valid during access
            // bits above the listed fields read as zero
            case (paddr)
                ECI_CTRL_OFS:  prdata_r <= {31'h0000_0000, en_r};
                ECI_OUT_OFS:   prdata_r <= {31'h0000_0000, out_r};
                ECI_PINS_OFS:  prdata_r <= {25'h000_0000, stat_r};
                ECI_ISTAT_OFS: prdata_r <= {25'h000_0000, istat_r | pulse_r};
                ECI_IMASK_OFS: prdata_r <= {25'h000_0000, imask_r};
                default:       prdata_r <= 32'h0000_0000;
            endcase
        end
    end
    // read data is captured at setup and must be the live register value
    chk_pins_read: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite && paddr == ECI_PINS_OFS
        |=> prdata == {25'h000_0000, $past(stat_r)}) else $error("pins read wrong");
    chk_ctrl_read: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite && paddr == ECI_CTRL_OFS
        |=> prdata == {31'h0000_0000, $past(en_r)}) else $error("ctrl read wrong");

    // ==========================================================
    // checks
    // ==========================================================
    chk_cmd_disabled: assert property (@(posedge pclk) disable iff (!presetn)
        !en_r |=> pulse_r == 7'h00) else $error("command acted while disabled");
    chk_start_edge: assert property (@(posedge pclk) disable iff (!presetn)
        en_r && $past(cmd_seq_start_n) && !cmd_seq_start_n |=> seq_start_pulse)
        else $error("start edge missed");
    chk_off_edge: assert property (@(posedge pclk) disable iff (!presetn)
        en_r && fall[ECI_C_OFF] |=> !output_on) else $error("off edge missed");
    chk_power_line: assert property (@(posedge pclk) disable iff (!presetn)
        en_r |=> st_power == $past(src_power_on)) else $error("power line wrong");
    chk_busy_line: assert property (@(posedge pclk) disable iff (!presetn)
        en_r |=> st_busy == $past(sw_busy)) else $error("busy line wrong");
    chk_output_line: assert property (@(posedge pclk) disable iff (!presetn)
        en_r |=> st_output == $past(out_r)) else $error("output line wrong");
    chk_limit_line: assert property (@(posedge pclk) disable iff (!presetn)
        en_r && (pos_peak_current_limit_flag || neg_peak_current_limit_flag ||
                 rms_current_limit_flag || power_limit_flag) |=> st_limit)
        else $error("limiter line low");
    chk_limit_clear: assert property (@(posedge pclk) disable iff (!presetn)
        en_r && !pos_peak_current_limit_flag && !neg_peak_current_limit_flag &&
        !rms_current_limit_flag && !power_limit_flag |=> !st_limit)
        else $error("limiter line stuck high");
    chk_sync_follow: assert property (@(posedge pclk) disable iff (!presetn)
        en_r |=> st_seq_sync == $past(seq_sync_in) && st_trigger == $past(seq_trig_in))
        else $error("sync lines wrong");
    chk_quiet_disabled: assert property (@(posedge pclk) disable iff (!presetn)
        !en_r ##1 !$past(en_r) |-> stat_r == 7'h00) else $error("pins not idle");
    chk_spare_low: assert property (@(posedge pclk) disable iff (!presetn)
        st_spare == 7'h00) else $error("spare output active");
endmodule : eci_ext_ctrl_io

//--- test/eci_ctrl_model.sv
`timescale 1ns/10ps
// ==========================================================
// outside controller: drives command lines, idle high as the pull-ups hold them
// ==========================================================
module eci_ctrl_model (
    input  wire logic       pclk,
    output logic      [6:0] cmd_n,
    output logic            undef_line
);
    // lines start released, so the pull-up level shows
    initial begin
        cmd_n      = 7'h7f;
        undef_line = 1'b1;
    end
    // high-to-low step on every line set in lines; returns at the edge that
    // samples the low level; the mask form lets two lines fall in one cycle
    task automatic strike_set(input logic [6:0] lines);
        @(posedge pclk);
        cmd_n      <= cmd_n & ~lines;
        undef_line <= ~undef_line;              // wiggle that must change nothing
        @(posedge pclk);
    endtask : strike_set
    // one line only
    task automatic strike(input int idx);
        strike_set(7'(1 << idx));
    endtask : strike
    // back to idle so the next step is a fresh edge
    task automatic rest();
        @(posedge pclk);
        cmd_n <= 7'h7f;
    endtask : rest
endmodule : eci_ctrl_model

//--- test/external_control_io_test.sv
`timescale 1ns/10ps
// ==========================================================
// bench: apb tasks plus a command line controller
// ==========================================================
module external_control_io_test;
    import eci_pkg::*;
    logic        pclk = 1'b0, presetn = 1'b0;             // 20 MHz, reset low 3 cycles
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, q;
    logic        pready, pslverr, e, irq, output_on, out_e;
    logic        pw = 1'b0, busy = 1'b0, trig = 1'b0;     // device state levels
    logic [4:0]  pls;                                      // start, stop, hold, br1, br2
    logic [3:0]  lim = 4'h0;                               // pos, neg, rms, power limiters
    logic [1:0]  sync = 2'b00, st_sync;
    logic [6:0]  cmd_n, st_spare;
    logic        st_pw, st_out, st_lim, st_busy, st_trig, undef_line;
    int          error_cnt = 0, n_tests = 0;

    eci_ext_ctrl_io dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cmd_out_off_n(cmd_n[0]), .cmd_out_on_n(cmd_n[1]),
        .cmd_seq_start_n(cmd_n[2]), .cmd_seq_stop_n(cmd_n[3]), .cmd_seq_hold_n(cmd_n[4]),
        .cmd_seq_br1_n(cmd_n[5]), .cmd_seq_br2_n(cmd_n[6]), .undef_in(undef_line),
        .src_power_on(pw), .sw_busy(busy), .pos_peak_current_limit_flag(lim[0]),
        .neg_peak_current_limit_flag(lim[1]), .rms_current_limit_flag(lim[2]),
        .power_limit_flag(lim[3]), .seq_sync_in(sync), .seq_trig_in(trig),
        .seq_start_pulse(pls[0]), .seq_stop_pulse(pls[1]), .seq_hold_pulse(pls[2]),
        .seq_br1_pulse(pls[3]), .seq_br2_pulse(pls[4]), .output_on(output_on),
        .st_power(st_pw), .st_output(st_out), .st_limit(st_lim), .st_busy(st_busy),
        .st_seq_sync(st_sync), .st_trigger(st_trig), .st_spare(st_spare), .irq(irq));
    eci_ctrl_model ctl_u (.pclk(pclk), .cmd_n(cmd_n), .undef_line(undef_line));

    // ==========================================================
    // clock, compare and bus tasks
    // ==========================================================
    always #25 pclk = ~pclk;
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : check
    // setup then access; request held until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdc(input string name, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(name, q, exp);
    endtask : rdc
    // five input patterns; pins must follow one edge later, or stay low when off
    task automatic stat(input logic en);
        logic [13:0] x;
        for (int k = 0; k < 5; k++) begin
            @(posedge pclk);
            pw <= k[0];
            busy <= k[1];
            lim <= 4'(5'h01 << k);
            sync <= 2'(k);
            trig <= ~k[0];
            @(posedge pclk);
            #1;
            x = {~k[0], 2'(k), k[1], k < 4, out_e, k[0], 7'h00};
            check("status", {st_trig, st_sync, st_busy, st_lim, st_out, st_pw, st_spare},
                  en ? x : 14'h0000);
            if (en) rdc("pins", ECI_PINS_OFS, {25'h0, x[13:7]});
        end
    endtask : stat
    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : final_report

    // ==========================================================
    // main sequence
    // ==========================================================
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rdc("ctrl", ECI_CTRL_OFS, 32'h0000_0000);
        rdc("imask", ECI_IMASK_OFS, 32'h0000_0000);
        out_e = 1'b0;
        stat(1'b0);
        ctl_u.strike(ECI_C_ON);
        #1;
        check("ignored", {pls, output_on}, 32'h0000_0000);
        ctl_u.rest();
        rdc("istat", ECI_ISTAT_OFS, 32'h0000_0000);
        apb(1'b1, ECI_CTRL_OFS, 32'h0000_0001);
        rdc("ctrl on", ECI_CTRL_OFS, 32'h0000_0001);
        apb(1'b1, ECI_OUT_OFS, 32'h0000_0001);
        rdc("out", ECI_OUT_OFS, 32'h0000_0001);
        check("pslverr mapped", e, 32'h0000_0000);
        out_e = 1'b1;
        stat(1'b1);
        // event with mask clear: sticky bit, interrupt quiet
        ctl_u.strike(ECI_C_START);
        ctl_u.rest();
        #1;
        check("irq masked", irq, 32'h0000_0000);
        rdc("istat", ECI_ISTAT_OFS, 32'h0000_0004);
        apb(1'b1, ECI_IMASK_OFS, 32'h0000_007f);
        rdc("imask set", ECI_IMASK_OFS, 32'h0000_007f);
        for (int i = 0; i < ECI_NCMD; i++) begin
            ctl_u.strike(i);
            #1;
            check("pulses", pls, i >= 2 ? 5'(1 << (i - 2)) : 5'h00);
            check("output_on", output_on, i >= 1);
            ctl_u.rest();
            #1;
            check("irq", irq, 32'h0000_0001);
            rdc("istat", ECI_ISTAT_OFS, 1 << i);
            #1;
            check("irq cleared", irq, 32'h0000_0000);
        end
        // off and on struck together: off must win
        ctl_u.strike_set(7'h03);
        #1;
        check("off wins", output_on, 32'h0000_0000);
        ctl_u.rest();
        rdc("istat both", ECI_ISTAT_OFS, 32'h0000_0003);
        rdc("unmapped", 12'h020, 32'h0000_0000);
        check("pslverr", e, 32'h0000_0001);
        // a refused write must not disturb the enable
        apb(1'b1, 12'h020, 32'h0000_0000);
        check("pslverr wr", e, 32'h0000_0001);
        rdc("ctrl kept", ECI_CTRL_OFS, 32'h0000_0001);
        apb(1'b1, ECI_CTRL_OFS, 32'h0000_0000);
        stat(1'b0);
        final_report();
    end
    // watchdog: the sequence needs well under 5000 cycles
    initial begin
        #(50 * 5000);
        error_cnt++;
        final_report();
    end
endmodule : external_control_io_test
